// File: design/keypad_regs.svh
`ifndef KEYPAD_REGS_SVH
`define KEYPAD_REGS_SVH

// ****************************************
// Pins and matrix
// ****************************************
`define KP_PINS 18
`define KP_ROWS 8
`define KP_COLS 10
`define KP_FIFO_DEPTH 10

// ****************************************
// Register offsets (I2C register pointer)
// ****************************************
`define KP_REG_STATUS 5'h00
`define KP_REG_EVCOUNT 5'h01
`define KP_REG_EVENT 5'h02
`define KP_CFG_BASE 5'h03
`define KP_REG_KEYSEL 5'h03
`define KP_REG_GPODIR 5'h06
`define KP_REG_GPODATA 5'h09
`define KP_REG_GPIINTEN 5'h0c
`define KP_REG_GPILEVEL 5'h0f
`define KP_REG_PULLOFF 5'h12
`define KP_REG_CTRL 5'h15
`define KP_CFG_LAST 5'h15
`define KP_REG_GPISTATE 5'h16
`define KP_REG_GPISTATE_LAST 5'h18
`define KP_CFG_COUNT 19

// ****************************************
// Fields and reset values
// ****************************************
`define KP_CTRL_KEYIE 0
`define KP_CTRL_OVFIE 1
`define KP_CTRL_LOCK 2
`define KP_CTRL_LOCKIE 3
`define KP_CTRL_SENSA 4
`define KP_CTRL_SENSB 5
`define KP_CTRL_GPIEV 6
`define KP_CFG_RESET 8'h00
`define KP_GPI_CODE_BASE 7'h61

// ****************************************
// Timing
// ****************************************
`define KP_CLK_PERIOD_NS 8
`define KP_DEBOUNCE_NS 50000
`define KP_SCAN_SETTLE_NS 2000

`endif

// File: design/keypad_pkg.sv
`default_nettype none
`include "keypad_regs.svh"

package keypad_pkg;
  typedef logic [`KP_PINS-1:0] pin_vec_t;
  typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_WRITE, I2C_READ} i2c_state_e;
endpackage : keypad_pkg

`default_nettype wire

// File: design/debounce_filter.sv
`timescale 1ns/10ps
`default_nettype none

module debounce_filter #(
  parameter int Cycles = 6250
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Filtered line
  input wire logic din,
  output var logic dout
);
  localparam int CntW = $clog2(Cycles + 1);
  logic [CntW-1:0] cnt_q;

  if (Cycles < 1) begin : g_chk
    $error("debounce_filter: Cycles must be at least one");
  end

  // Idle level of every filtered line is high (pulled up)
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      dout <= 1'b1;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (cnt_q == CntW'(Cycles - 1)) begin
      cnt_q <= '0;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  a_deb_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(dout) |-> $past(cnt_q) == CntW'(Cycles - 1))
    else $error("output changed before the debounce period");
  a_deb_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (din == dout) |=> (cnt_q == '0) && $stable(dout))
    else $error("short pulse not discarded");
endmodule : debounce_filter

`default_nettype wire

// File: design/keypad_gpio_expander.sv
// Contract
// - After reset every row and column pin acts as plain input.
// - Matrix scans up to eight rows by ten columns, eighty key codes.
// - Pins outside the matrix are each input or output; two columns may sense light.
// - Sensor column used as keypad line: comparator off, pin joins matrix.
// - Sensor column used as light input: leaves matrix, comparator on.
// - Sensor column used as plain pin: no matrix, no comparator.
// - Ten-entry event buffer with counter; overflow wraps and flags interrupt.
// - Keylock; option chooses whether locked key events still interrupt.
// - Reset pin and inputs ignore changes shorter than the debounce period.
// - Per-input interrupt with selectable active level; pull-ups under software control.
// - Register pointer advances by itself on successive I2C reads.
// - Host talks over two-wire I2C plus one interrupt line only.
`timescale 1ns/10ps
`default_nettype none
`include "keypad_regs.svh"

module keypad_gpio_expander #(
  parameter int FifoDepth = `KP_FIFO_DEPTH,
  parameter int DebounceCycles = (`KP_DEBOUNCE_NS + `KP_CLK_PERIOD_NS - 1) / `KP_CLK_PERIOD_NS,
  parameter int ScanSettle = (`KP_SCAN_SETTLE_NS + `KP_CLK_PERIOD_NS - 1) / `KP_CLK_PERIOD_NS,
  parameter logic [6:0] DevAddr = 7'h2a
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Device reset pin
  input wire logic extRstNIn,
  // I2C link
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Interrupt
  output logic intOut,
  output logic intOe,
  // Row and column pins
  input wire keypad_pkg::pin_vec_t pinIn,
  output keypad_pkg::pin_vec_t pinOut,
  output keypad_pkg::pin_vec_t pinOe,
  output keypad_pkg::pin_vec_t pullEn,
  // Light comparators
  output logic [1:0] cmpEn
);
  import keypad_pkg::*;

  localparam int Rows = `KP_ROWS;
  localparam int Cols = `KP_COLS;
  localparam int Keys = Rows * Cols;
  localparam int Pins = `KP_PINS;

  if (FifoDepth < 1 || FifoDepth > 15 || ScanSettle < 1 || ScanSettle > 65535) begin : g_chk
    $error("keypad_gpio_expander: parameter out of range");
  end

  // ****************************************
  // Reset and input synchronisers
  // ****************************************
  logic [1:0] rstSync_q;
  logic coreRstN;
  logic [Pins+2:0] inMeta_q, inSync_q;
  logic sclD_q, sdaD_q;
  logic [Pins:0] debOut;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rstSync_q <= 2'h0;
    else rstSync_q <= {rstSync_q[0], 1'b1};
  end
  wire sysRstN = rstSync_q[1];

  always_ff @(posedge clk_sys or negedge sysRstN) begin
    if (!sysRstN) begin
      inMeta_q <= '1;
      inSync_q <= '1;
      sclD_q <= 1'b1;
      sdaD_q <= 1'b1;
    end else begin
      inMeta_q <= {extRstNIn, sclIn, sdaIn, pinIn};
      inSync_q <= inMeta_q;
      sclD_q <= inSync_q[Pins+1];
      sdaD_q <= inSync_q[Pins];
    end
  end

  wire [Pins:0] debIn = {inSync_q[Pins+2], inSync_q[Pins-1:0]};
  for (genvar i = 0; i <= Pins; i++) begin : g_deb
    debounce_filter #(.Cycles(DebounceCycles)) u_deb (
      .clk_sys(clk_sys),
      .rst_n(sysRstN),
      .din(debIn[i]),
      .dout(debOut[i])
    );
  end

  // Filtered reset pin resets all but the reset and input synchronisers, the filters and the event memory
  always_ff @(posedge clk_sys or negedge sysRstN) begin
    if (!sysRstN) coreRstN <= 1'b0;
    else coreRstN <= debOut[Pins];
  end

  wire [Pins-1:0] pinS = inSync_q[Pins-1:0];
  wire [Pins-1:0] deb = debOut[Pins-1:0];

  // ****************************************
  // Configuration bytes and pin functions
  // ****************************************
  logic [7:0] cfg_q [0:`KP_CFG_COUNT-1];
  localparam int Ks = `KP_REG_KEYSEL - `KP_CFG_BASE;
  localparam int Gd = `KP_REG_GPODIR - `KP_CFG_BASE;
  localparam int Go = `KP_REG_GPODATA - `KP_CFG_BASE;
  localparam int Ie = `KP_REG_GPIINTEN - `KP_CFG_BASE;
  localparam int Lv = `KP_REG_GPILEVEL - `KP_CFG_BASE;
  localparam int Po = `KP_REG_PULLOFF - `KP_CFG_BASE;
  localparam int Ct = `KP_REG_CTRL - `KP_CFG_BASE;

  wire [Pins-1:0] keySel = {cfg_q[Ks+2][1:0], cfg_q[Ks+1], cfg_q[Ks]};
  wire [Pins-1:0] gpoDir = {cfg_q[Gd+2][1:0], cfg_q[Gd+1], cfg_q[Gd]};
  wire [Pins-1:0] gpoData = {cfg_q[Go+2][1:0], cfg_q[Go+1], cfg_q[Go]};
  wire [Pins-1:0] gpiIntEn = {cfg_q[Ie+2][1:0], cfg_q[Ie+1], cfg_q[Ie]};
  wire [Pins-1:0] gpiLevel = {cfg_q[Lv+2][1:0], cfg_q[Lv+1], cfg_q[Lv]};
  wire [Pins-1:0] pullOff = {cfg_q[Po+2][1:0], cfg_q[Po+1], cfg_q[Po]};
  wire [7:0] ctrl = cfg_q[Ct];
  wire keyIntEn = ctrl[`KP_CTRL_KEYIE];
  wire ovfIntEn = ctrl[`KP_CTRL_OVFIE];
  wire lockOn = ctrl[`KP_CTRL_LOCK];
  wire lockIntEn = ctrl[`KP_CTRL_LOCKIE];
  wire gpiEvEn = ctrl[`KP_CTRL_GPIEV];
  wire [1:0] sensorSel = {ctrl[`KP_CTRL_SENSB], ctrl[`KP_CTRL_SENSA]};

  // Sensor choice outranks keypad choice on the two sensor columns
  wire [Pins-1:0] sensorMask = {sensorSel, {(Pins - 2){1'b0}}};
  wire [Pins-1:0] matrixMask = keySel & ~sensorMask;
  wire [Pins-1:0] gpoMask = gpoDir & ~matrixMask & ~sensorMask;
  wire [Pins-1:0] gpiMask = ~matrixMask & ~gpoMask & ~sensorMask;
  wire [Rows-1:0] rowMask = matrixMask[Rows-1:0];
  wire [Cols-1:0] colMask = matrixMask[Pins-1:Rows];

  // ****************************************
  // Matrix scan
  // ****************************************
  logic [2:0] scanRow_q;
  logic [15:0] settle_q;
  logic [Keys-1:0] keyState_q;
  logic [3:0] keyCol;

  wire rowOn = rowMask[scanRow_q];
  wire [Cols-1:0] pressedRow = rowOn ? (~pinS[Pins-1:Rows] & colMask) : '0;
  wire [Cols-1:0] keyDiff = pressedRow ^ keyState_q[scanRow_q * Cols +: Cols];
  wire settled = settle_q == 16'(ScanSettle - 1);
  wire keyPush = settled & (|keyDiff);
  wire keyPressNow = pressedRow[keyCol];
  wire [6:0] keyCode = 7'(scanRow_q * Cols + keyCol + 1);
  wire [Rows-1:0] rowDrive = rowMask & 8'(8'h01 << scanRow_q);

  always_comb begin
    keyCol = 4'h0;
    for (int c = Cols - 1; c >= 0; c--) begin
      if (keyDiff[c]) keyCol = 4'(c);
    end
  end

  // One change per cycle; the row is held until all its changes are logged
  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      scanRow_q <= 3'h0;
      settle_q <= 16'h0000;
      keyState_q <= '0;
    end else if (!settled) begin
      settle_q <= settle_q + 16'h0001;
    end else if (keyPush) begin
      keyState_q[scanRow_q * Cols + keyCol] <= keyPressNow;
    end else begin
      settle_q <= 16'h0000;
      scanRow_q <= scanRow_q + 3'h1;
    end
  end

  // ****************************************
  // Input change detection
  // ****************************************
  logic [Pins-1:0] gpiPrev_q, gpiPrev_d;
  logic [4:0] gpiIdx;
  wire [Pins-1:0] gpiChg = (deb ^ gpiPrev_q) & gpiMask;
  wire gpiTake = (|gpiChg) & ~keyPush;
  wire gpiActive = deb[gpiIdx] == gpiLevel[gpiIdx];
  wire gpiPush = gpiTake & gpiEvEn;
  wire gpiSet = gpiTake & gpiIntEn[gpiIdx] & gpiActive;

  always_comb begin
    gpiIdx = 5'h00;
    for (int p = Pins - 1; p >= 0; p--) begin
      if (gpiChg[p]) gpiIdx = 5'(p);
    end
    gpiPrev_d = (gpiPrev_q & gpiMask) | (deb & ~gpiMask);
    if (gpiTake) gpiPrev_d[gpiIdx] = deb[gpiIdx];
  end

  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) gpiPrev_q <= '1;
    else gpiPrev_q <= gpiPrev_d;
  end

  // ****************************************
  // Event buffer
  // ****************************************
  logic [7:0] evMem_q [0:FifoDepth-1];
  logic [3:0] wrPtr_q, rdPtr_q, count_q;
  logic popReq;
  wire evPush = keyPush | gpiPush;
  wire [7:0] evWord = keyPush ? {keyPressNow, keyCode}
                              : {gpiActive, 7'(`KP_GPI_CODE_BASE + gpiIdx)};
  wire evFull = count_q == 4'(FifoDepth);
  wire evPop = popReq & (count_q != 4'h0);
  wire evOver = evPush & evFull & ~evPop;
  wire [7:0] evHead = (count_q != 4'h0) ? evMem_q[rdPtr_q] : 8'h00;

  function automatic logic [3:0] ptrNext(input logic [3:0] p);
    return (p == 4'(FifoDepth - 1)) ? 4'h0 : p + 4'h1;
  endfunction : ptrNext

  always_ff @(posedge clk_sys) begin
    if (evPush) evMem_q[wrPtr_q] <= evWord;
  end

  // On overflow the oldest entry is dropped
  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      wrPtr_q <= 4'h0;
      rdPtr_q <= 4'h0;
      count_q <= 4'h0;
    end else begin
      if (evPush) wrPtr_q <= ptrNext(wrPtr_q);
      if (evPop || evOver) rdPtr_q <= ptrNext(rdPtr_q);
      if (evPush && !evPop && !evFull) count_q <= count_q + 4'h1;
      else if (evPop && !evPush) count_q <= count_q - 4'h1;
    end
  end

  // ****************************************
  // Flags and interrupt
  // ****************************************
  logic keyFlag_q, gpiFlag_q, ovfFlag_q;
  logic [2:0] flagClr;
  wire keySet = keyPush & (~lockOn | lockIntEn);
  wire intPending = (keyFlag_q & keyIntEn) | gpiFlag_q | (ovfFlag_q & ovfIntEn);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      keyFlag_q <= 1'b0;
      gpiFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
      intOe <= 1'b0;
    end else begin
      keyFlag_q <= (keyFlag_q & ~flagClr[0]) | keySet;
      gpiFlag_q <= (gpiFlag_q & ~flagClr[1]) | gpiSet;
      ovfFlag_q <= (ovfFlag_q & ~flagClr[2]) | evOver;
      intOe <= intPending;
    end
  end
  assign intOut = 1'b0;
  assign sdaOut = 1'b0;

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      pinOut <= '0;
      pinOe <= '0;
      pullEn <= '1;
      cmpEn <= 2'h0;
    end else begin
      pinOut <= gpoData & gpoMask;
      pinOe <= gpoMask | {{Cols{1'b0}}, rowDrive};
      pullEn <= ~pullOff & ~sensorMask;
      cmpEn <= sensorSel;
    end
  end

  // ****************************************
  // I2C slave
  // ****************************************
  i2c_state_e i2cState_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q, tx_q, readData;
  logic [4:0] ptr_q;
  logic first_q, ackNext_q;

  wire sclS = inSync_q[Pins+1];
  wire sdaS = inSync_q[Pins];
  wire sclRise = sclS & ~sclD_q;
  wire sclFall = ~sclS & sclD_q;
  wire i2cStart = sclS & sclD_q & sdaD_q & ~sdaS;
  wire i2cStop = sclS & sclD_q & ~sdaD_q & sdaS;
  wire [7:0] rxByte = {shift_q[6:0], sdaS};
  wire byteDone = sclRise & (bitCnt_q == 4'h7) & (i2cState_q != I2C_IDLE);
  wire loadTx = sclFall & (bitCnt_q == 4'h0) & (i2cState_q == I2C_READ);
  wire regWrite = byteDone & (i2cState_q == I2C_WRITE) & ~first_q;
  wire inCfg = (ptr_q >= `KP_CFG_BASE) && (ptr_q <= `KP_CFG_LAST);
  wire [4:0] cfgIdx = ptr_q - `KP_CFG_BASE;
  wire [4:0] gpiSel = ptr_q - `KP_REG_GPISTATE;
  wire [7:0] statusByte = {4'h0, lockOn, ovfFlag_q, gpiFlag_q, keyFlag_q};
  wire [7:0] gpiByte = (gpiSel == 5'h00) ? deb[7:0]
                     : (gpiSel == 5'h01) ? deb[15:8] : {6'h00, deb[17:16]};
  wire inGpi = (ptr_q >= `KP_REG_GPISTATE) && (ptr_q <= `KP_REG_GPISTATE_LAST);

  assign readData = (ptr_q == `KP_REG_STATUS) ? statusByte
                  : (ptr_q == `KP_REG_EVCOUNT) ? {4'h0, count_q}
                  : (ptr_q == `KP_REG_EVENT) ? evHead
                  : inCfg ? cfg_q[cfgIdx]
                  : inGpi ? gpiByte : 8'h00;
  assign popReq = loadTx & (ptr_q == `KP_REG_EVENT);
  assign flagClr = (regWrite && ptr_q == `KP_REG_STATUS) ? rxByte[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      for (int k = 0; k < `KP_CFG_COUNT; k++) cfg_q[k] <= `KP_CFG_RESET;
    end else if (regWrite && inCfg) begin
      cfg_q[cfgIdx] <= rxByte;
    end
  end

  always_ff @(posedge clk_sys or negedge coreRstN) begin
    if (!coreRstN) begin
      i2cState_q <= I2C_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 5'h00;
      first_q <= 1'b0;
      ackNext_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (i2cStart || i2cStop) begin
      i2cState_q <= i2cStart ? I2C_ADDR : I2C_IDLE;
      bitCnt_q <= 4'h0;
      ackNext_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (sclRise && i2cState_q != I2C_IDLE) begin
      if (bitCnt_q < 4'h8) shift_q <= rxByte;
      bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
      // Host NACK ends a read burst
      if (bitCnt_q == 4'h8 && i2cState_q == I2C_READ && sdaS) i2cState_q <= I2C_IDLE;
      if (byteDone && i2cState_q == I2C_ADDR) begin
        if (rxByte[7:1] == DevAddr) begin
          i2cState_q <= rxByte[0] ? I2C_READ : I2C_WRITE;
          ackNext_q <= 1'b1;
          first_q <= 1'b1;
        end else begin
          i2cState_q <= I2C_IDLE;
        end
      end else if (byteDone && i2cState_q == I2C_WRITE) begin
        // Read bytes are acknowledged by the host, never by this side
        ackNext_q <= 1'b1;
        first_q <= 1'b0;
        ptr_q <= first_q ? rxByte[4:0] : ptr_q + 5'h01;
      end
    end else if (sclFall) begin
      if (bitCnt_q == 4'h8) begin
        sdaOe <= ackNext_q;
        ackNext_q <= 1'b0;
      end else if (loadTx) begin
        tx_q <= {readData[6:0], 1'b0};
        sdaOe <= ~readData[7];
        ptr_q <= ptr_q + 5'h01;
      end else if (i2cState_q == I2C_READ && bitCnt_q != 4'h0) begin
        sdaOe <= ~tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end else begin
        sdaOe <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!coreRstN);

  a_default_gpi: assert property ((keySel == '0) && (gpoDir == '0) |=> pinOe == '0)
    else $error("pin driven while configured as input");
  a_key_code: assert property (keyPush |-> (keyCode >= 7'h01) && (keyCode <= 7'(Keys)))
    else $error("key code outside matrix range");
  a_gpo_drive: assert property (gpoDir[0] && !keySel[0] |=> pinOe[0] && pinOut[0] == $past(gpoData[0]))
    else $error("output pin not driven from its data bit");
  a_col_keypad: assert property (keySel[16] && !sensorSel[0] |-> colMask[8] ##1 !cmpEn[0])
    else $error("keypad column still feeds comparator");
  a_col_sensor: assert property (sensorSel[0] |-> !colMask[8] ##1 cmpEn[0] && !pullEn[16])
    else $error("sensor column not routed to comparator");
  a_col_gpio: assert property (!sensorSel[0] && !keySel[16] |-> !colMask[8] ##1 !cmpEn[0])
    else $error("plain column reaches matrix or comparator");
  a_fifo_wrap: assert property (evPush && evFull && !evPop |=> ovfFlag_q && evFull)
    else $error("overflow not wrapped and flagged");
  a_fifo_bound: assert property (count_q <= 4'(FifoDepth))
    else $error("event count above buffer depth");
  a_lock_quiet: assert property (keyPush && lockOn && !lockIntEn && !keyFlag_q |=> !keyFlag_q)
    else $error("locked key event raised a flag");
  a_gpi_level: assert property (gpiSet |=> gpiFlag_q ##1 intOe)
    else $error("active input level not flagged");
  a_pull_ctrl: assert property (!pullOff[0] |=> pullEn[0])
    else $error("pull-up not enabled");
  a_ptr_incr: assert property (loadTx |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("register pointer did not advance on read");
  a_sda_idle: assert property (i2cState_q == I2C_IDLE && $past(i2cState_q) == I2C_IDLE |-> !sdaOe)
    else $error("SDA driven while bus idle");
  a_int_follow: assert property (keySet && keyIntEn |-> ##2 intOe)
    else $error("interrupt not asserted for pending key flag");
  a_int_release: assert property (!intPending |=> !intOe)
    else $error("interrupt held with no pending flag");
endmodule : keypad_gpio_expander

`default_nettype wire

// File: tb/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model #(
  parameter logic [6:0] Addr = 7'h2a
) (
  // Clock
  input wire logic clk_sys,
  // Wire levels
  output var logic sclOut,
  output var logic sdaPull,
  input wire logic sdaIn
);
  // ****************************************
  // Bit level, SCL stands high outside frames
  // ****************************************
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // Quarter bit of 4 clocks keeps each SCL phase at 8 clocks
  task automatic q();
    repeat (4) @(negedge clk_sys);
  endtask : q
  task automatic bitOut(input logic b);
    sdaPull = !b;
    q();
    sclOut = 1'b1;
    q();
    q();
    sclOut = 1'b0;
    q();
  endtask : bitOut
  task automatic bitIn(output logic b);
    sdaPull = 1'b0;
    q();
    sclOut = 1'b1;
    q();
    b = sdaIn;
    q();
    sclOut = 1'b0;
    q();
  endtask : bitIn
  task automatic start();
    sdaPull = 1'b0;
    sclOut = 1'b1;
    q();
    sdaPull = 1'b1;
    q();
    sclOut = 1'b0;
    q();
  endtask : start
  task automatic stop();
    sdaPull = 1'b1;
    q();
    sclOut = 1'b1;
    q();
    sdaPull = 1'b0;
    q();
  endtask : stop
  // ****************************************
  // Byte level, MSB first
  // ****************************************
  task automatic byteOut(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i]);
    end
    bitIn(a);
  endtask : byteOut
  task automatic byteIn(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i]);
    end
    bitOut(last);
  endtask : byteIn
  task automatic writeReg(input logic [4:0] p, input logic [7:0] d);
    start();
    byteOut({Addr, 1'b0});
    byteOut({3'h0, p});
    byteOut(d);
    stop();
  endtask : writeReg
  task automatic readRegs(input logic [4:0] p, input int n, output logic [7:0] d [12]);
    start();
    byteOut({Addr, 1'b0});
    byteOut({3'h0, p});
    start();
    byteOut({Addr, 1'b1});
    for (int i = 0; i < n; i++) begin
      byteIn(d[i], i == n - 1);
    end
    stop();
  endtask : readRegs
endmodule : i2c_host_model

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import keypad_pkg::*;
  `define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic keyDn = 1'b0;
  logic gpiLo = 1'b0;
  logic extRstN = 1'b1;
  logic sclW, sdaPull, sdaW, sdaOut, sdaOe, intOut, intOe;
  pin_vec_t pinW, pinOut, pinOe, pullEn;
  logic [1:0] cmpEn;
  logic [7:0] rb [12];
  int bad_count = 0;
  int n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  // ****************************************
  // Wires: SDA pulled up, key joins row 7 to column 9
  // ****************************************
  assign sdaW = !(sdaPull | sdaOe);
  always_comb begin
    pinW = ~pinOe | pinOut;
    if (keyDn && pinOe[7] && !pinOut[7]) pinW[17] = 1'b0;
    if (gpiLo) pinW[0] = 1'b0;
  end
  keypad_gpio_expander #(.DebounceCycles(8), .ScanSettle(4)) keypad_gpio_expander_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .extRstNIn(extRstN), .sclIn(sclW), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .pinIn(pinW),
    .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn), .cmpEn(cmpEn));
  i2c_host_model i2c_host_model_inst (
    .clk_sys(clk_sys), .sclOut(sclW), .sdaPull(sdaPull), .sdaIn(sdaW));
  task automatic wr(input logic [4:0] p, input logic [7:0] d);
    i2c_host_model_inst.writeReg(p, d);
  endtask : wr
  task automatic rd(input logic [4:0] p, input int n);
    i2c_host_model_inst.readRegs(p, n, rb);
  endtask : rd
  task automatic waitInt(input logic lvl);
    for (int i = 0; i < 300 && intOe !== lvl; i++) @(negedge clk_sys);
  endtask : waitInt
  task automatic key(input logic d);
    @(negedge clk_sys);
    keyDn = d;
    repeat (100) @(negedge clk_sys);
  endtask : key
  task automatic t_reset();
    `CHK("pinOe", 18'h0, pinOe)
    `CHK("pullEn", 18'h3ffff, pullEn)
    `CHK("cmpEn", 2'h0, cmpEn)
    `CHK("intOe", 1'b0, intOe)
    `CHK("intOut", 1'b0, intOut)
    `CHK("sdaOut", 1'b0, sdaOut)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_pins();
    wr(5'h03, 8'h80);
    wr(5'h05, 8'h03);
    rd(5'h03, 3);
    `CHK("keysel0", 8'h80, rb[0])
    `CHK("keysel2", 8'h03, rb[2])
    `CHK("cmpKey", 2'h0, cmpEn)
    wr(5'h15, 8'h30);
    repeat (2) @(negedge clk_sys);
    `CHK("cmpSens", 2'h3, cmpEn)
    wr(5'h05, 8'h02);
    wr(5'h15, 8'h00);
    wr(5'h06, 8'h01);
    wr(5'h09, 8'h01);
    wr(5'h12, 8'h02);
    repeat (2) @(negedge clk_sys);
    `CHK("cmpGpio", 2'h0, cmpEn)
    `CHK("gpoOe", 2'h1, pinOe[1:0])
    `CHK("gpoVal", 1'b1, pinOut[0])
    `CHK("pullOff", 2'h1, pullEn[1:0])
    wr(5'h06, 8'h00);
    $display("t_pins done");
  endtask : t_pins
  task automatic t_key();
    wr(5'h15, 8'h01);
    key(1'b1);
    waitInt(1'b1);
    `CHK("keyInt", 1'b1, intOe)
    key(1'b0);
    rd(5'h00, 3);
    `CHK("status", 8'h01, rb[0])
    `CHK("count", 8'h02, rb[1])
    `CHK("press80", 8'hd0, rb[2])
    rd(5'h02, 1);
    `CHK("rel80", 8'h50, rb[0])
    wr(5'h00, 8'h07);
    waitInt(1'b0);
    `CHK("intClr", 1'b0, intOe)
    $display("t_key done");
  endtask : t_key
  task automatic t_ovf();
    wr(5'h15, 8'h02);
    for (int i = 0; i < 6; i++) begin
      key(1'b1);
      key(1'b0);
    end
    rd(5'h00, 3);
    `CHK("ovfFlag", 8'h04, rb[0] & 8'h04)
    `CHK("ovfCount", 8'h0a, rb[1])
    `CHK("ovfHead", 8'hd0, rb[2])
    `CHK("ovfInt", 1'b1, intOe)
    // Pointer moves on after each byte, so each pop is its own read
    for (int i = 0; i < 9; i++) rd(5'h02, 1);
    `CHK("ovfTail", 8'h50, rb[0])
    wr(5'h00, 8'h07);
    $display("t_ovf done");
  endtask : t_ovf
  task automatic t_lock();
    wr(5'h15, 8'h05);
    key(1'b1);
    rd(5'h01, 2);
    `CHK("lockCnt", 8'h01, rb[0])
    `CHK("lockInt", 1'b0, intOe)
    `CHK("lockEv", 8'hd0, rb[1])
    wr(5'h15, 8'h0d);
    key(1'b0);
    waitInt(1'b1);
    `CHK("lockIe", 1'b1, intOe)
    wr(5'h15, 8'h00);
    wr(5'h00, 8'h07);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_gpi();
    wr(5'h15, 8'h40);
    wr(5'h0c, 8'h01);
    @(negedge clk_sys);
    gpiLo = 1'b1;
    repeat (4) @(negedge clk_sys);
    gpiLo = 1'b0;
    repeat (40) @(negedge clk_sys);
    `CHK("glitch", 1'b0, intOe)
    gpiLo = 1'b1;
    waitInt(1'b1);
    rd(5'h00, 1);
    `CHK("gpiFlag", 8'h02, rb[0] & 8'h02)
    rd(5'h02, 1);
    `CHK("lockRel", 8'h50, rb[0])
    rd(5'h02, 1);
    `CHK("gpiEv", 8'he1, rb[0])
    @(negedge clk_sys);
    gpiLo = 1'b0;
    repeat (40) @(negedge clk_sys);
    wr(5'h00, 8'h07);
    waitInt(1'b0);
    `CHK("gpiClr", 1'b0, intOe)
    $display("t_gpi done");
  endtask : t_gpi
  task automatic t_ext();
    @(negedge clk_sys);
    extRstN = 1'b0;
    repeat (4) @(negedge clk_sys);
    extRstN = 1'b1;
    repeat (20) @(negedge clk_sys);
    rd(5'h03, 1);
    `CHK("rstGlitch", 8'h80, rb[0])
    extRstN = 1'b0;
    repeat (20) @(negedge clk_sys);
    `CHK("rstPinOe", 18'h0, pinOe)
    extRstN = 1'b1;
    repeat (20) @(negedge clk_sys);
    rd(5'h03, 1);
    `CHK("rstKeySel", 8'h00, rb[0])
    $display("t_ext done");
  endtask : t_ext
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    t_reset();
    t_pins();
    t_key();
    t_ovf();
    t_lock();
    t_gpi();
    t_ext();
    stop_test();
  end
  // Longest legal run is well under half this span
  initial begin
    #500us;
    bad_count++;
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
